// ==== rtl/cmbf_top.sv ====
// Transmit message FIFO pointer keeper, buffer fetcher and frame field decoder
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cmbf_top
  import cmbf_pkg::*;
#(
  parameter int MAX_DEPTH = 32
) (
  input  wire  logic        CLOCK_I,
  input  wire  logic        RST_I,
  input  wire  logic        HSEL_I,
  input  wire  logic [31:0] HADDR_I,
  input  wire  logic [1:0]  HTRANS_I,
  input  wire  logic        HWRITE_I,
  input  wire  logic [2:0]  HSIZE_I,
  input  wire  logic [31:0] HWDATA_I,
  input  wire  logic        HREADY_I,
  output var   logic        HREADYOUT_O,
  output var   logic        HRESP_O,
  output var   logic [31:0] HRDATA_O,
  output var   logic        MEM_REQ_O,
  output var   logic [31:0] MEM_ADDR_O,
  input  wire  logic        MEM_ACK_I,
  input  wire  logic [31:0] MEM_RDATA_I,
  output var   logic        FRAME_VALID_O,
  output var   logic [10:0] FRAME_BASE_ID_O,
  output var   logic [17:0] FRAME_EXT_ID_O,
  output var   logic        FRAME_IDE_O,
  output var   logic        FRAME_SRR_O,
  output var   logic        FRAME_RTR_O,
  output var   logic [3:0]  FRAME_DLC_O,
  output var   logic [3:0]  FRAME_LEN_O,
  output var   logic [63:0] FRAME_DATA_O,
  input  wire  logic        FRAME_DONE_I
);

  // ==========================================================================
  // Elaboration check
  if (MAX_DEPTH < 1 || MAX_DEPTH > DEPTH_LIMIT) begin : g_depth_check
    $error("MAX_DEPTH must lie between 1 and 32");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0]    base;
    logic [4:0]     last;
    logic           txsel;
    logic           sendreq;
    logic [4:0]     head;
    logic [4:0]     tail;
    logic [5:0]     count;
    cmbf_state_type st;
    logic [1:0]     widx;
    logic [31:0]    w0;
    logic [31:0]    w1;
    logic [31:0]    w2;
    logic           dph;
    logic           dwr;
    logic [7:0]     daddr;
    logic [31:0]    rdata;
    logic           mreq;
    logic [31:0]    maddr;
    logic           fvalid;
    logic [10:0]    base_id;
    logic [17:0]    ext_id;
    logic           ide;
    logic           srr;
    logic           rtr;
    logic [3:0]     dlc;
    logic [3:0]     len;
    logic [63:0]    data;
  } cmbf_state_struct_type;

  cmbf_state_struct_type s_q;
  cmbf_state_struct_type s_d;

  // ==========================================================================
  // Helpers
  function automatic logic [4:0] wrap_next(input logic [4:0] p, input logic [4:0] last);
    wrap_next = (p == last) ? 5'h00 : p + 5'h01;
  endfunction

  function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [4:0] idx);
    slot_addr = base + {23'h000000, idx, 4'h0};
  endfunction

  // Byte length from the length code
  function automatic logic [3:0] dlc_len(input logic [3:0] dlc);
    dlc_len = dlc[DLC_MSB] ? FULL_LEN : {1'b0, dlc[2:0]};
  endfunction

  // ==========================================================================
  // Combinational next state
  logic        addr_ok;
  logic        wr_base;
  logic        wr_ctrl;
  logic        adv;
  logic        full;
  logic        take;
  logic [31:0] uptr;

  always_comb begin
    s_d     = s_q;
    addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
    uptr    = slot_addr(s_q.base, s_q.head);
    full    = ({1'b0, s_q.count} > {2'b00, s_q.last});
    wr_base = s_q.dph && s_q.dwr && (s_q.daddr == REG_BASE_OFS);
    wr_ctrl = s_q.dph && s_q.dwr && (s_q.daddr == REG_CTRL_OFS);
    adv     = wr_ctrl && HWDATA_I[CTRL_ADV_POS] && !full;
    take    = 1'b0;

    // Bus address phase; read data is loaded here so it stands in the data phase
    s_d.dph   = addr_ok;
    s_d.dwr   = addr_ok && HWRITE_I;
    s_d.daddr = {HADDR_I[7:2], 2'b00};
    s_d.rdata = 32'h0000_0000;
    if (addr_ok && !HWRITE_I) begin
      case ({HADDR_I[7:2], 2'b00})
        REG_BASE_OFS: s_d.rdata = s_q.base;
        REG_CTRL_OFS: begin
          s_d.rdata[CTRL_SEND_POS]                  = s_q.sendreq;
          s_d.rdata[CTRL_TXSEL_POS]                 = s_q.txsel;
          s_d.rdata[CTRL_LAST_LSB+PTR_W-1:CTRL_LAST_LSB] = s_q.last;
        end
        REG_UPTR_OFS: s_d.rdata = uptr;
        REG_STAT_OFS: begin
          s_d.rdata[CNT_W-1:0]                        = s_q.count;
          s_d.rdata[STAT_HEAD_LSB+PTR_W-1:STAT_HEAD_LSB] = s_q.head;
          s_d.rdata[STAT_TAIL_LSB+PTR_W-1:STAT_TAIL_LSB] = s_q.tail;
          s_d.rdata[STAT_BUSY_POS]                    = (s_q.st != ST_IDLE);
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Fetch sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.sendreq && s_q.txsel && s_q.count != 6'h00) begin
          s_d.maddr = slot_addr(s_q.base, s_q.tail);
          s_d.widx  = 2'h0;
          s_d.mreq  = 1'b1;
          s_d.st    = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (MEM_ACK_I) begin
          s_d.mreq = 1'b0;
          case (s_q.widx)
            2'h0:    s_d.w0 = MEM_RDATA_I;
            2'h1:    s_d.w1 = MEM_RDATA_I;
            2'h2:    s_d.w2 = MEM_RDATA_I;
            default: s_d.w2 = s_q.w2;
          endcase
          if (s_q.widx == 2'(MSG_WORDS - 1)) begin
            // Fields copied across, except that ext_id and srr are zeroed on standard frames and len is decoded from dlc
            s_d.base_id = s_q.w0[BASE_ID_MSB:0];
            s_d.ide     = s_q.w1[IDE_POS];
            s_d.ext_id  = s_q.w1[IDE_POS] ? s_q.w1[EXT_ID_MSB:EXT_ID_LSB] : 18'h00000;
            s_d.srr     = s_q.w1[IDE_POS] & s_q.w1[SRR_POS];
            s_d.rtr     = s_q.w1[RTR_POS];
            s_d.dlc     = s_q.w1[DLC_MSB:0];
            s_d.len     = dlc_len(s_q.w1[DLC_MSB:0]);
            s_d.data    = {MEM_RDATA_I, s_q.w2};
            s_d.fvalid  = 1'b1;
            s_d.st      = ST_HOLD;
          end else begin
            s_d.widx = s_q.widx + 2'h1;
            s_d.st   = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        s_d.maddr = s_q.maddr + WORD_BYTES;
        s_d.mreq  = 1'b1;
        s_d.st    = ST_FETCH;
      end
      ST_HOLD: begin
        if (FRAME_DONE_I) begin
          s_d.fvalid = 1'b0;
          s_d.tail   = wrap_next(s_q.tail, s_q.last);
          take       = 1'b1;
          s_d.st     = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Queue bookkeeping; a refused advance on a full FIFO is dropped
    if (adv) begin
      s_d.head = wrap_next(s_q.head, s_q.last);
    end
    s_d.count = s_q.count + {5'h00, adv} - {5'h00, take};
    if (take && s_q.count == 6'h01 && !adv) begin
      s_d.sendreq = 1'b0;
    end

    // Register writes; software setting the send request wins over the clear
    if (wr_base) begin
      s_d.base  = {HWDATA_I[31:4], 4'h0};
      s_d.head  = 5'h00;
      s_d.tail  = 5'h00;
      s_d.count = 6'h00;
    end
    if (wr_ctrl) begin
      if (HWDATA_I[CTRL_SEND_POS]) begin
        s_d.sendreq = 1'b1;
      end
      s_d.txsel = HWDATA_I[CTRL_TXSEL_POS];
      if (HWDATA_I[CTRL_LAST_LSB+PTR_W-1:CTRL_LAST_LSB] <= 5'(MAX_DEPTH - 1)) begin
        s_d.last = HWDATA_I[CTRL_LAST_LSB+PTR_W-1:CTRL_LAST_LSB];
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q         <= '0;
      s_q.base    <= BASE_RST;
      s_q.last    <= LAST_RST;
      s_q.st      <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops except HRESP_O, which is the inverse of ready_q
  // Zero wait states: the slave never stalls and always answers OKAY
  logic ready_q;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= 1'b1;
    end
  end

  assign HREADYOUT_O     = ready_q;
  assign HRESP_O         = !ready_q;
  assign HRDATA_O        = s_q.rdata;
  assign MEM_REQ_O       = s_q.mreq;
  assign MEM_ADDR_O      = s_q.maddr;
  assign FRAME_VALID_O   = s_q.fvalid;
  assign FRAME_BASE_ID_O = s_q.base_id;
  assign FRAME_EXT_ID_O  = s_q.ext_id;
  assign FRAME_IDE_O     = s_q.ide;
  assign FRAME_SRR_O     = s_q.srr;
  assign FRAME_RTR_O     = s_q.rtr;
  assign FRAME_DLC_O     = s_q.dlc;
  assign FRAME_LEN_O     = s_q.len;
  assign FRAME_DATA_O    = s_q.data;

endmodule

`default_nettype wire

// ==== rtl/cmbf_pkg.sv ====
// Constants and types for the transmit message buffer fetch and decode block
package cmbf_pkg;

  // ==========================================================================
  // Message buffer layout in system memory
  localparam int          MSG_WORDS      = 4;
  localparam logic [31:0] MSG_BYTES      = 32'h0000_0010;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam int          BASE_ID_MSB    = 10;
  localparam int          SRR_POS        = 29;
  localparam int          IDE_POS        = 28;
  localparam int          EXT_ID_MSB     = 27;
  localparam int          EXT_ID_LSB     = 10;
  localparam int          RTR_POS        = 9;
  localparam int          DLC_MSB        = 3;
  localparam logic [3:0]  FULL_LEN       = 4'h8;

  // ==========================================================================
  // FIFO sizing
  localparam int          PTR_W          = 5;
  localparam int          CNT_W          = 6;
  localparam int          DEPTH_LIMIT    = 32;

  // ==========================================================================
  // Register map (byte offsets on the AHB-Lite slave)
  localparam logic [7:0]  REG_BASE_OFS   = 8'h00;
  localparam logic [7:0]  REG_CTRL_OFS   = 8'h04;
  localparam logic [7:0]  REG_UPTR_OFS   = 8'h08;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h0C;

  // Control register fields
  localparam int          CTRL_SEND_POS  = 3;
  localparam int          CTRL_TXSEL_POS = 7;
  localparam int          CTRL_ADV_POS   = 13;
  localparam int          CTRL_LAST_LSB  = 16;

  // Status register fields
  localparam int          STAT_HEAD_LSB  = 8;
  localparam int          STAT_TAIL_LSB  = 16;
  localparam int          STAT_BUSY_POS  = 24;

  // Reset values
  localparam logic [31:0] BASE_RST       = 32'h0000_0000;
  localparam logic [4:0]  LAST_RST       = 5'h00;

  // ==========================================================================
  // Fetch sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_GAP,
    ST_HOLD
  } cmbf_state_type;

endpackage

// ==== dv/cmbf_asserts.sv ====
// Port checks for the buffer fetch and frame decode block
`timescale 1ns/1ps
`default_nettype none
module cmbf_asserts (
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        MEM_REQ_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic        MEM_ACK_I,
  input wire logic [31:0] MEM_RDATA_I,
  input wire logic        FRAME_VALID_O,
  input wire logic [17:0] FRAME_EXT_ID_O,
  input wire logic        FRAME_IDE_O,
  input wire logic        FRAME_SRR_O,
  input wire logic [3:0]  FRAME_DLC_O,
  input wire logic [3:0]  FRAME_LEN_O,
  input wire logic [63:0] FRAME_DATA_O,
  input wire logic        FRAME_DONE_I
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  property p_okay; !HRESP_O && HREADYOUT_O; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_hold; MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O); endproperty
  a_hold: assert property (p_hold) else $error("read request dropped early");
  property p_drop; MEM_REQ_O && MEM_ACK_I |=> !MEM_REQ_O; endproperty
  a_drop: assert property (p_drop) else $error("read request kept after ack");
  property p_step;
    MEM_REQ_O && MEM_ACK_I && MEM_ADDR_O[3:2] != 2'h3 |=>
      !MEM_REQ_O ##1 (MEM_REQ_O && MEM_ADDR_O == $past(MEM_ADDR_O, 2) + 32'h4);
  endproperty
  a_step: assert property (p_step) else $error("next buffer word not at +4");
  property p_idle; FRAME_VALID_O |-> !MEM_REQ_O; endproperty
  a_idle: assert property (p_idle) else $error("fetch while frame pending");
  property p_cap;
    MEM_REQ_O && MEM_ACK_I && MEM_ADDR_O[3:2] == 2'h3 |=>
      FRAME_VALID_O && FRAME_DATA_O[63:32] == $past(MEM_RDATA_I);
  endproperty
  a_cap: assert property (p_cap) else $error("high data word not placed");
  property p_len;
    FRAME_VALID_O |-> FRAME_LEN_O == (FRAME_DLC_O[3] ? 4'h8 : {1'b0, FRAME_DLC_O[2:0]});
  endproperty
  a_len: assert property (p_len) else $error("byte count wrong for code");
  property p_std; FRAME_VALID_O && !FRAME_IDE_O |-> FRAME_EXT_ID_O == 18'h0 && !FRAME_SRR_O;
  endproperty
  a_std: assert property (p_std) else $error("standard frame kept extension");
  property p_keep; FRAME_VALID_O && !FRAME_DONE_I |=> FRAME_VALID_O && $stable(FRAME_DATA_O);
  endproperty
  a_keep: assert property (p_keep) else $error("frame changed before done");
  property p_done; FRAME_VALID_O && FRAME_DONE_I |=> !FRAME_VALID_O; endproperty
  a_done: assert property (p_done) else $error("frame kept after done");
endmodule
bind cmbf_top cmbf_asserts u_cmbf_asserts (.*);
`default_nettype wire

// ==== dv/cmbf_ram_model.sv ====
// System RAM model answering buffer word reads with random stalls
`timescale 1ns/1ps
`default_nettype none
module cmbf_ram_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output var  logic        ack_o,
  output var  logic [31:0] rdata_o
);
  logic [31:0] mem [0:255];
  int          seed = 86706;
  logic        go;
  // ==========================================================================
  // Plain word reads; data inverted between answers so stale reads show
  always @(posedge clk_i) begin
    go = ($random(seed) & 1) == 1;
    ack_o   <= !rst_i && req_i && !ack_o && go;
    rdata_o <= (req_i && !ack_o && go) ? mem[addr_i[9:2]] : ~rdata_o;
  end
endmodule
`default_nettype wire

// ==== dv/cmbf_bench.sv ====
// Self-checking bench for the buffer fetch and frame decode block
`timescale 1ns/1ps
`default_nettype none
module cmbf_bench;
  logic CLOCK_I = 0, RST_I = 1, HSEL_I = 0, HWRITE_I = 0, FRAME_DONE_I = 0;
  logic [1:0]  HTRANS_I = 0;
  logic [2:0]  HSIZE_I = 3'h2;
  logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O, MEM_ADDR_O, MEM_RDATA_I;
  logic HREADY_I, HREADYOUT_O, HRESP_O, MEM_REQ_O, MEM_ACK_I, FRAME_VALID_O;
  logic FRAME_IDE_O, FRAME_SRR_O, FRAME_RTR_O;
  logic [10:0] FRAME_BASE_ID_O;
  logic [17:0] FRAME_EXT_ID_O;
  logic [3:0]  FRAME_DLC_O, FRAME_LEN_O;
  logic [63:0] FRAME_DATA_O;
  logic [31:0] r, a, w0, w1, w2, w3;
  logic [63:0] exp_q[$];
  int checked = 0, miscompares = 0, seed = 86706, head = 0, k;
  assign HREADY_I = HREADYOUT_O;
  cmbf_top #(.MAX_DEPTH(4)) u_cmbf_top (.*);
  cmbf_ram_model u_cmbf_ram_model (.clk_i(CLOCK_I), .rst_i(RST_I), .req_i(MEM_REQ_O),
    .addr_i(MEM_ADDR_O), .ack_o(MEM_ACK_I), .rdata_o(MEM_RDATA_I));
  initial forever #20 CLOCK_I = ~CLOCK_I;
  // ==========================================================================
  // Tasks
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Single word transfer; entered just after a rising edge
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    HSEL_I <= 1; HTRANS_I <= 2'h2; HADDR_I <= {24'h0, ad}; HWRITE_I <= w;
    do @(posedge CLOCK_I); while (HREADYOUT_O !== 1'b1);
    HSEL_I <= 0; HTRANS_I <= 2'h0; HWDATA_I <= d;
    do @(posedge CLOCK_I); while (HREADYOUT_O !== 1'b1);
    q = HRDATA_O;
  endtask
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLOCK_I);
    miscompares++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge CLOCK_I);
    RST_I <= 0;
    ahb(0, 8'h04, 0, r); chk("ctrl reset", r, 0);
    ahb(1, 8'h00, 32'h10F, r);
    ahb(0, 8'h00, 0, r); chk("base", r, 32'h100);
    // Size first: an advance in the same write would wrap on the old size
    ahb(1, 8'h04, 32'h0003_0080, r);
    ahb(0, 8'h04, 0, r); chk("ctrl size", r, 32'h0003_0080);
    ahb(0, 8'h10, 0, r); chk("unmapped", r, 0);
    for (int i = 0; i < 8; i++) begin
      a = 32'h100 + head * 16;
      ahb(0, 8'h08, 0, r); chk("head addr", r, a);
      // Unused and reserved bits zero, SRR set on extended frames
      w0 = $random(seed) & 32'h7FF;
      w1 = ($random(seed) & 32'h2FFF_FE00) | (i[0] ? 32'h3000_0000 : 0) | ((i * 3) % 16);
      w2 = $random(seed);
      w3 = $random(seed);
      exp_q.push_back({w3, w2});
      u_cmbf_ram_model.mem[a[9:2]] = w0;
      u_cmbf_ram_model.mem[a[9:2] + 1] = w1;
      u_cmbf_ram_model.mem[a[9:2] + 2] = w2;
      u_cmbf_ram_model.mem[a[9:2] + 3] = w3;
      ahb(1, 8'h04, 32'h0003_2088, r);
      k = 0;
      while (FRAME_VALID_O !== 1'b1 && k < 300) begin @(posedge CLOCK_I); k++; end
      chk("frame valid", FRAME_VALID_O, 1);
      chk("base id", FRAME_BASE_ID_O, w0[10:0]);
      chk("ide", FRAME_IDE_O, w1[28]);
      chk("ext id", FRAME_EXT_ID_O, w1[28] ? w1[27:10] : 18'h0);
      chk("srr", FRAME_SRR_O, w1[28] & w1[29]);
      chk("rtr", FRAME_RTR_O, w1[9]);
      chk("dlc", FRAME_DLC_O, w1[3:0]);
      chk("len", FRAME_LEN_O, w1[3] ? 4'h8 : {1'b0, w1[2:0]});
      chk("data", FRAME_DATA_O, exp_q.pop_front());
      FRAME_DONE_I <= 1;
      @(posedge CLOCK_I);
      FRAME_DONE_I <= 0;
      head = (head + 1) % 4;
      ahb(0, 8'h0C, 0, r); chk("status", r & 32'h001F_1F3F, (head << 16) | (head << 8));
      ahb(0, 8'h04, 0, r); chk("ctrl", r, 32'h0003_0080);
    end
    // Fifth advance on a full FIFO of four is refused
    for (int i = 0; i < 5; i++) ahb(1, 8'h04, 32'h0003_2080, r);
    ahb(0, 8'h0C, 0, r); chk("full count", r & 32'h3F, 4);
    ahb(0, 8'h08, 0, r); chk("full head", r, 32'h100 + head * 16);
    end_of_test();
  end
endmodule
`default_nettype wire
